// ---- queue_mem.sv ----
// Storage array for one queue of W-bit entries, with registered read data.
// Assumes the caller keeps pointers and counts.
`timescale 1ns/1ps
module queue_mem #(
  parameter int W = 8,
  parameter int D = 16,
  parameter int A = 4
) (
  input  wire logic         clk,   // Clock.
  input  wire logic         we,    // Write strobe.
  input  wire logic [A-1:0] waddr, // Write address.
  input  wire logic [W-1:0] wdata, // Write data.
  input  wire logic [A-1:0] raddr, // Read address.
  output logic      [W-1:0] rdata  // Registered read data.
);

  logic [W-1:0] mem [D];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // A write to the head entry passes straight through.
  always_ff @(posedge clk) begin
    if (we && waddr == raddr) begin
      rdata <= wdata;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule

// ---- serial_peer.sv ----
// Remote serial device facing the core's line pins.
// Assumes the bench gives bit period in clocks and bits to keep.
`timescale 1ns/1ps
module serial_peer (
  input  wire logic clk,     // Clock.
  input  wire logic line_rx, // From core.
  output logic      line_tx, // To core.
  input  int        bc,      // Clocks a bit.
  input  int        nb       // Bits kept.
);
  logic [15:0] q [$];
  logic [15:0] r;
  initial line_tx = 1'b1;
  // Falling edge starts a frame; bits sampled mid-period.
  always begin
    @(negedge line_rx);
    r = 16'h0;
    repeat (bc / 2) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      repeat (bc) @(posedge clk);
      r[i] = line_rx;
    end
    repeat (bc / 2) @(posedge clk);
    q.push_back(r);
  end
  // Start bit, then bits low first, then idle high.
  task automatic send(logic [15:0] f, int n);
    line_tx <= 1'b0;
    repeat (bc) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      line_tx <= f[i];
      repeat (bc) @(posedge clk);
    end
    line_tx <= 1'b1;
  endtask
endmodule

// ---- serial_port_core.sv ----
// Asynchronous serial port with AHB-Lite register access.
// Assumes serial and modem inputs synchronous to hclk.
`timescale 1ns/1ps
module serial_port_core
  import serial_port_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic        hclk,            // Clock.
  input  wire logic        hresetn,         // Async reset, low.
  input  wire logic        hsel,            // Slave select.
  input  wire logic [31:0] haddr,           // Byte address.
  input  wire logic [1:0]  htrans,          // Transfer type.
  input  wire logic        hwrite,          // Write access.
  input  wire logic [2:0]  hsize,           // Transfer size.
  input  wire logic        hready,          // Bus ready.
  input  wire logic [31:0] hwdata,          // Write data.
  output logic      [31:0] hrdata,          // Read data.
  output logic             hreadyout,       // Slave ready.
  output logic             hresp,           // Response, always OKAY.
  input  wire logic        serial_in,       // Serial line input.
  output logic             serial_out,      // Serial line output.
  output logic             infrared_tx_out, // Infrared output.
  input  wire logic        cts_n,           // Clear to send, low.
  input  wire logic        dsr_n,           // Data set ready, low.
  input  wire logic        ri_n,            // Ring indicator, low.
  input  wire logic        dcd_n,           // Carrier detect, low.
  output logic             rts_n,           // Request to send, low.
  output logic             dtr_n            // Terminal ready, low.
);
  import serial_port_pkg::*;

  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_START = 5'b00010,
    S_DATA  = 5'b00100,
    S_PAR   = 5'b01000,
    S_STOP  = 5'b10000
  } bit_state_e;

  line_ctrl_s   lc_q;
  logic [7:0]   ier_q, mcr_q, scr_q;
  logic [15:0]  div_q, baud_cnt_q;
  logic         tick_q;
  logic         qen_q, dma_q;
  logic [1:0]   lvl_q;
  logic         ph_q, ph_wr_q, ph_map_q;
  logic [2:0]   ph_idx_q;
  logic         wr_go, rd_go;
  logic [7:0]   wdat, rd_val;
  logic         loop;
  logic [AW-1:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
  logic [AW:0]  tx_cnt_q, rx_cnt_q, rx_err_cnt_q, cap, lvl_n;
  logic [7:0]   tx_head;
  rx_entry_s    rx_head, rx_new;
  logic         tx_push, tx_pop, rx_push, rx_pop, rx_full;
  logic         tx_clr, rx_clr;
  bit_state_e   tx_st_q, rx_st_q;
  logic [5:0]   tx_tk_q, rx_tk_q, stop_len;
  logic [2:0]   tx_bit_q, rx_bit_q, last_bit;
  logic [7:0]   tx_sh_q, rx_sh_q, mask;
  logic         tx_line_q, tx_par_q, rx_par_q, rx_prev_q, rxd;
  logic         oe_q, pe_q, fe_q, bi_q, thre_irq_q;
  modem_in_s    ms_now, ms_prev_q;
  logic [3:0]   msd_q;
  logic [3:0]   pend;
  logic [2:0]   id_code;

  function automatic logic par_bit(input logic [7:0] d,
                                   input line_ctrl_s c);
    if (c.stick) begin
      return ~c.even;
    end
    return c.even ? ~(^d) : (^d);
  endfunction

  assign wdat     = hwdata[7:0];
  assign wr_go    = ph_q && ph_wr_q && ph_map_q;
  assign rd_go    = ph_q && !ph_wr_q && !hreadyout;
  assign loop     = mcr_q[MC_LOOP];
  assign mask     = 8'hff >> (2'd3 - lc_q.wl);
  assign last_bit = {1'b1, lc_q.wl};
  assign stop_len = !lc_q.stop_x ? TICKS_BIT :
                    (lc_q.wl == 2'd0 ? TICKS_STOP15 : TICKS_STOP2);
  assign cap      = qen_q ? (AW+1)'(DEPTH) : (AW+1)'(1);
  assign rx_full  = rx_cnt_q >= cap;
  assign rxd      = loop ? tx_line_q : serial_in;

  // Bus slave: writes finish with no wait, reads take one wait state.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_q     <= 1'b0;
      ph_wr_q  <= 1'b0;
      ph_map_q <= 1'b0;
      ph_idx_q <= 3'h0;
    end else if (hreadyout) begin
      ph_q     <= hsel && hready && htrans[1];
      ph_wr_q  <= hwrite;
      ph_map_q <= haddr[31:5] == 27'h0;
      ph_idx_q <= haddr[4:2];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hrdata    <= 32'h0;
      hresp     <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (hreadyout && hsel && hready && htrans[1] && !hwrite) begin
        hreadyout <= 1'b0;
      end else if (rd_go) begin
        hreadyout <= 1'b1;
        hrdata    <= {24'h0, ph_map_q ? rd_val : 8'h0};
      end
    end
  end

  always_comb begin
    rd_val = 8'h0;
    unique case (ph_idx_q)
      IDX_DATA:  rd_val = lc_q.dlab ? div_q[7:0] : rx_head.data;
      IDX_IER:   rd_val = lc_q.dlab ? div_q[15:8] : ier_q;
      IDX_IDENT: rd_val = {qen_q, qen_q, 2'b00, id_code, ~|pend};
      IDX_LCR:   rd_val = lc_q;
      IDX_MCR:   rd_val = {3'b000, mcr_q[4:0]};
      IDX_LSR:   rd_val = {qen_q && rx_err_cnt_q != '0,
                           tx_cnt_q == '0 && tx_st_q == S_IDLE,
                           tx_cnt_q == '0, bi_q, fe_q, pe_q, oe_q,
                           rx_cnt_q != '0};
      IDX_MSR:   rd_val = {ms_now, msd_q};
      IDX_SCR:   rd_val = scr_q;
    endcase
  end

  // Control registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lc_q  <= LCR_RST;
      ier_q <= IER_RST;
      mcr_q <= MCR_RST;
      scr_q <= SCR_RST;
      div_q <= DIV_RST;
    end else if (wr_go) begin
      unique case (ph_idx_q)
        IDX_DATA: if (lc_q.dlab) div_q[7:0] <= wdat;
        IDX_IER:
          if (lc_q.dlab) begin
            div_q[15:8] <= wdat;
          end else begin
            ier_q <= {4'h0, wdat[3:0]};
          end
        IDX_LCR:   lc_q  <= wdat;
        IDX_MCR:   mcr_q <= {3'b000, wdat[4:0]};
        IDX_SCR:   scr_q <= wdat;
        default: ;
      endcase
    end
  end

  // Queue control; DMA and level bits are stored only with queues enabled; the DMA bit drives nothing.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      qen_q <= 1'b0;
      dma_q <= 1'b0;
      lvl_q <= 2'b00;
    end else if (wr_go && ph_idx_q == IDX_IDENT) begin
      qen_q <= wdat[QC_ENABLE];
      if (wdat[QC_ENABLE]) begin
        dma_q <= wdat[QC_DMA];
        lvl_q <= wdat[QC_LVL_LO +: 2];
      end
    end
  end

  assign tx_clr = wr_go && ph_idx_q == IDX_IDENT &&
                  (wdat[QC_TX_RESET] || wdat[QC_ENABLE] != qen_q);
  assign rx_clr = wr_go && ph_idx_q == IDX_IDENT &&
                  (wdat[QC_RX_RESET] || wdat[QC_ENABLE] != qen_q);

  // Baud generator: one tick every divisor clocks, zero stops it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      baud_cnt_q <= 16'h0;
      tick_q     <= 1'b0;
    end else if (div_q == 16'h0 || baud_cnt_q >= div_q - 16'h1) begin
      baud_cnt_q <= 16'h0;
      tick_q     <= div_q != 16'h0;
    end else begin
      baud_cnt_q <= baud_cnt_q + 16'h1;
      tick_q     <= 1'b0;
    end
  end

  // Transmit queue.
  assign tx_push = wr_go && ph_idx_q == IDX_DATA && !lc_q.dlab &&
                   tx_cnt_q < cap;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_wp_q  <= '0;
      tx_rp_q  <= '0;
      tx_cnt_q <= '0;
    end else if (tx_clr) begin
      tx_wp_q  <= '0;
      tx_rp_q  <= '0;
      tx_cnt_q <= '0;
    end else begin
      if (tx_push) tx_wp_q <= tx_wp_q + 1'b1;
      if (tx_pop) tx_rp_q <= tx_rp_q + 1'b1;
      tx_cnt_q <= tx_cnt_q + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
    end
  end

  queue_mem #(.W(8), .D(DEPTH), .A(AW)) u_tx_mem (
    .clk   (hclk),
    .we    (tx_push),
    .waddr (tx_wp_q),
    .wdata (wdat),
    .raddr (tx_rp_q),
    .rdata (tx_head)
  );

  // Transmitter: the head byte is taken at the end of the start bit.
  assign tx_pop = tick_q && tx_st_q == S_START &&
                  tx_tk_q == TICKS_BIT - 6'h1 && tx_cnt_q != '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_st_q   <= S_IDLE;
      tx_tk_q   <= 6'h0;
      tx_bit_q  <= 3'h0;
      tx_sh_q   <= 8'h0;
      tx_par_q  <= 1'b0;
      tx_line_q <= 1'b1;
    end else if (tx_st_q == S_IDLE) begin
      tx_line_q <= 1'b1;
      tx_tk_q   <= 6'h0;
      if (tx_cnt_q != '0 && !tx_clr) begin
        tx_st_q   <= S_START;
        tx_line_q <= 1'b0;
      end
    end else if (tick_q) begin
      tx_tk_q <= tx_tk_q + 6'h1;
      unique case (tx_st_q)
        S_START:
          if (tx_tk_q == TICKS_BIT - 6'h1) begin
            tx_tk_q   <= 6'h0;
            tx_sh_q   <= {1'b0, tx_head[7:1]};
            tx_line_q <= tx_head[0];
            tx_par_q  <= par_bit(tx_head & mask, lc_q);
            tx_bit_q  <= 3'h0;
            tx_st_q   <= tx_pop ? S_DATA : S_IDLE;
          end
        S_DATA:
          if (tx_tk_q == TICKS_BIT - 6'h1) begin
            tx_tk_q  <= 6'h0;
            tx_bit_q <= tx_bit_q + 3'h1;
            tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
            if (tx_bit_q != last_bit) begin
              tx_line_q <= tx_sh_q[0];
            end else if (lc_q.par_en) begin
              tx_line_q <= tx_par_q;
              tx_st_q   <= S_PAR;
            end else begin
              tx_line_q <= 1'b1;
              tx_st_q   <= S_STOP;
            end
          end
        S_PAR:
          if (tx_tk_q == TICKS_BIT - 6'h1) begin
            tx_tk_q   <= 6'h0;
            tx_line_q <= 1'b1;
            tx_st_q   <= S_STOP;
          end
        S_STOP:
          if (tx_tk_q == stop_len - 6'h1) begin
            tx_st_q <= S_IDLE;
          end
        default: tx_st_q <= S_IDLE;
      endcase
    end
  end

  // Line and modem pins, all registered.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_out      <= 1'b1;
      infrared_tx_out <= 1'b1;
      rts_n           <= 1'b1;
      dtr_n           <= 1'b1;
    end else begin
      serial_out      <= loop || (tx_line_q && !lc_q.brk);
      infrared_tx_out <= tx_line_q && !lc_q.brk;
      rts_n           <= loop || !mcr_q[MC_RTS];
      dtr_n           <= loop || !mcr_q[MC_DTR];
    end
  end

  // Receiver.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_st_q   <= S_IDLE;
      rx_tk_q   <= 6'h0;
      rx_bit_q  <= 3'h0;
      rx_sh_q   <= 8'h0;
      rx_par_q  <= 1'b0;
      rx_prev_q <= 1'b1;
      rx_push   <= 1'b0;
      rx_new    <= '0;
    end else begin
      rx_prev_q <= rxd;
      rx_push   <= 1'b0;
      if (rx_st_q == S_IDLE) begin
        rx_tk_q <= 6'h0;
        if (rx_prev_q && !rxd) begin
          rx_st_q <= S_START;
        end
      end else if (tick_q) begin
        rx_tk_q <= rx_tk_q + 6'h1;
        unique case (rx_st_q)
          S_START:
            if (rx_tk_q == TICKS_HALF - 6'h1) begin
              rx_tk_q  <= 6'h0;
              rx_bit_q <= 3'h0;
              rx_sh_q  <= 8'h0;
              rx_st_q  <= rxd ? S_IDLE : S_DATA;
            end
          S_DATA:
            if (rx_tk_q == TICKS_BIT - 6'h1) begin
              rx_tk_q           <= 6'h0;
              rx_sh_q[rx_bit_q] <= rxd;
              rx_bit_q          <= rx_bit_q + 3'h1;
              if (rx_bit_q == last_bit) begin
                rx_st_q <= lc_q.par_en ? S_PAR : S_STOP;
              end
            end
          S_PAR:
            if (rx_tk_q == TICKS_BIT - 6'h1) begin
              rx_tk_q  <= 6'h0;
              rx_par_q <= rxd;
              rx_st_q  <= S_STOP;
            end
          S_STOP:
            if (rx_tk_q == TICKS_BIT - 6'h1) begin
              rx_st_q      <= S_IDLE;
              rx_push      <= 1'b1;
              rx_new.data  <= rx_sh_q;
              rx_new.ferr  <= !rxd;
              rx_new.perr  <= lc_q.par_en &&
                              rx_par_q != par_bit(rx_sh_q, lc_q);
              rx_new.brk   <= !rxd && rx_sh_q == 8'h0 &&
                              !(lc_q.par_en && rx_par_q);
            end
          default: rx_st_q <= S_IDLE;
        endcase
      end
    end
  end

  // Receive queue; a byte arriving when full is dropped as overrun.
  assign rx_pop = rd_go && ph_idx_q == IDX_DATA && !lc_q.dlab &&
                  ph_map_q && rx_cnt_q != '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_wp_q      <= '0;
      rx_rp_q      <= '0;
      rx_cnt_q     <= '0;
      rx_err_cnt_q <= '0;
    end else if (rx_clr) begin
      rx_wp_q      <= '0;
      rx_rp_q      <= '0;
      rx_cnt_q     <= '0;
      rx_err_cnt_q <= '0;
    end else begin
      if (rx_push && !rx_full) rx_wp_q <= rx_wp_q + 1'b1;
      if (rx_pop) rx_rp_q <= rx_rp_q + 1'b1;
      rx_cnt_q <= rx_cnt_q + (AW+1)'(rx_push && !rx_full) -
                  (AW+1)'(rx_pop);
      rx_err_cnt_q <= rx_err_cnt_q +
                      (AW+1)'(rx_push && !rx_full &&
                              (rx_new.perr || rx_new.ferr || rx_new.brk)) -
                      (AW+1)'(rx_pop &&
                              (rx_head.perr || rx_head.ferr || rx_head.brk));
    end
  end

  queue_mem #(.W(11), .D(DEPTH), .A(AW)) u_rx_mem (
    .clk   (hclk),
    .we    (rx_push && !rx_full),
    .waddr (rx_wp_q),
    .wdata (rx_new),
    .raddr (rx_rp_q),
    .rdata (rx_head)
  );

  // Line status error flags; a new event beats the read clear.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      oe_q <= 1'b0;
      pe_q <= 1'b0;
      fe_q <= 1'b0;
      bi_q <= 1'b0;
    end else begin
      if (rd_go && ph_map_q && ph_idx_q == IDX_LSR) begin
        oe_q <= 1'b0;
        pe_q <= 1'b0;
        fe_q <= 1'b0;
        bi_q <= 1'b0;
      end
      if (rx_push && rx_full) oe_q <= 1'b1;
      if (rx_push && rx_new.perr) pe_q <= 1'b1;
      if (rx_push && rx_new.ferr) fe_q <= 1'b1;
      if (rx_push && rx_new.brk) bi_q <= 1'b1;
    end
  end

  // Modem status: pins, or modem control bits in loopback.
  always_comb begin
    if (loop) begin
      ms_now = {mcr_q[MC_IRQ], mcr_q[MC_RI], mcr_q[MC_DTR],
                mcr_q[MC_RTS]};
    end else begin
      ms_now = ~{dcd_n, ri_n, dsr_n, cts_n};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_prev_q <= '0;
      msd_q     <= 4'h0;
    end else begin
      ms_prev_q <= ms_now;
      if (rd_go && ph_map_q && ph_idx_q == IDX_MSR) begin
        msd_q <= 4'h0;
      end
      if (ms_now.cts != ms_prev_q.cts) msd_q[0] <= 1'b1;
      if (ms_now.dsr != ms_prev_q.dsr) msd_q[1] <= 1'b1;
      if (!ms_now.ri && ms_prev_q.ri) msd_q[2] <= 1'b1;
      if (ms_now.dcd != ms_prev_q.dcd) msd_q[3] <= 1'b1;
    end
  end

  // Transmit-empty source: set when the queue drains.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      thre_irq_q <= 1'b0;
    end else if (tx_pop && tx_cnt_q == (AW+1)'(1)) begin
      thre_irq_q <= 1'b1;
    end else if (tx_push ||
                 (rd_go && ph_map_q && ph_idx_q == IDX_IDENT &&
                  id_code == ID_TX)) begin
      thre_irq_q <= 1'b0;
    end
  end

  always_comb begin
    unique case (lvl_q)
      2'b00: lvl_n = (AW+1)'(1);
      2'b01: lvl_n = (AW+1)'(4);
      2'b10: lvl_n = (AW+1)'(8);
      2'b11: lvl_n = (AW+1)'(14);
    endcase
  end

  assign pend[3] = ier_q[2] && (oe_q || pe_q || fe_q || bi_q);
  assign pend[2] = ier_q[0] && rx_cnt_q >= (qen_q ? lvl_n : (AW+1)'(1));
  assign pend[1] = ier_q[1] && thre_irq_q;
  assign pend[0] = ier_q[3] && msd_q != 4'h0;

  always_comb begin
    if (pend[3]) begin
      id_code = ID_LINE;
    end else if (pend[2]) begin
      id_code = ID_RX;
    end else if (pend[1]) begin
      id_code = ID_TX;
    end else begin
      id_code = ID_MDM;
    end
  end

endmodule

// ---- serial_port_core_tb.sv ----
// Self-checking bench for the serial port core.
// Needs the core, its package, the peer model and the monitor.
`timescale 1ns/1ps
module serial_port_core_tb;
  import serial_port_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        serial_in, serial_out, infrared_tx_out, rts_n, dtr_n;
  logic        cts_n, dsr_n, ri_n, dcd_n;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [7:0]  rv, b, lc;
  logic [2:0]  md [5] = '{3'h0, 3'h1, 3'h3, 3'h7, 3'h5};
  logic [15:0] ex [$];
  int          n_errors, check_count, cyc, nb;
  serial_port_core u_serial_port_core (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout), .hwdata, .hrdata,
    .hreadyout, .hresp, .serial_in, .serial_out, .infrared_tx_out,
    .cts_n, .dsr_n, .ri_n, .dcd_n, .rts_n, .dtr_n);
  // Divisor 1 gives sixteen clocks a bit.
  serial_peer u_serial_peer (.clk(hclk), .line_rx(serial_out),
    .line_tx(serial_in), .bc(16), .nb);
  always #12.5 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      $display("MISMATCH timeout expected done seen hang");
      conclude();
    end
  end
  task automatic check(string n, logic [15:0] s, logic [15:0] e);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(logic w, logic [31:0] a, logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata[7:0];
  endtask
  task automatic wr(logic [2:0] i, logic [7:0] d);
    bus(1'b1, {27'h0, i, 2'b00}, d);
  endtask
  task automatic rd(string n, logic [2:0] i, logic [7:0] e);
    bus(1'b0, {27'h0, i, 2'b00}, 8'h00);
    check(n, rv, e);
  endtask
  function automatic logic [15:0] frame(logic [7:0] d, logic [7:0] c);
    logic [7:0] m;
    logic       p;
    m = d & (8'hff >> (3 - c[1:0]));
    p = c[5] ? !c[4] : (c[4] ? ~^m : ^m);
    return c[3] ? {8'h0, m} | (16'(p) << (c[1:0] + 5)) : {8'h0, m};
  endfunction
  task automatic tx(logic [7:0] d);
    ex.push_back(frame(d, lc));
    wr(IDX_DATA, d);
  endtask
  task automatic drain;
    while (ex.size() > 0) begin
      while (u_serial_peer.q.size() == 0) @(posedge hclk);
      check("frame", u_serial_peer.q.pop_front(), ex.pop_front());
    end
    repeat (48) @(posedge hclk);
  endtask
  task automatic rx(logic [15:0] f, logic [7:0] ls);
    u_serial_peer.send(f, 10);
    rd("status", IDX_LSR, ls);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    {cts_n, dsr_n, ri_n, dcd_n} = 4'hf;
    b = 8'($urandom(32'h2961)) | 8'h10;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd("ctl", IDX_LCR, LCR_RST);
    wr(IDX_LCR, 8'h80);
    rd("div_lo", IDX_DATA, DIV_RST[7:0]);
    rd("div_hi", IDX_IER, DIV_RST[15:8]);
    wr(IDX_DATA, 8'h01);
    wr(IDX_IER, 8'h00);
    wr(IDX_LCR, 8'h03);
    wr(IDX_IER, 8'h05);
    rd("irq_en", IDX_IER, 8'h05);
    wr(IDX_SCR, b);
    rd("scratch", IDX_SCR, b);
    bus(1'b0, 32'h40, 8'h00);
    check("unmapped", rv, 8'h00);
    $display("test registers done");
    for (int w = 0; w < 4; w++) begin
      for (int m = 0; m < 5; m++) begin
        lc = {2'b00, md[m], m[0], w[1:0]};
        nb = w + 5 + md[m][0];
        wr(IDX_LCR, lc);
        tx(8'($urandom));
        drain();
      end
    end
    wr(IDX_IDENT, 8'h01);
    rd("ident", IDX_IDENT, 8'hc1);
    for (int i = 0; i < 3; i++) tx(8'($urandom));
    drain();
    wr(IDX_IDENT, 8'h00);
    rd("ident", IDX_IDENT, 8'h01);
    $display("test transmit done");
    lc = 8'h1b;
    wr(IDX_LCR, lc);
    b = 8'($urandom) | 8'h01;
    rx(frame(b, lc) | 16'h200, 8'h61);
    rd("rx_data", IDX_DATA, b);
    rx(frame(b, lc) ^ 16'h300, 8'h65);
    rd("status", IDX_LSR, 8'h61);
    rd("rx_data", IDX_DATA, b);
    rx(frame(b, lc), 8'h69);
    rd("rx_data", IDX_DATA, b);
    rd("status", IDX_LSR, 8'h60);
    // Receive level of four: no receive source until the fourth byte.
    wr(IDX_IDENT, 8'h41);
    for (int i = 0; i < 4; i++) begin
      rx(frame(b, lc) | 16'h200, 8'h61);
      rd("ident", IDX_IDENT, i == 3 ? 8'hc4 : 8'hc1);
    end
    wr(IDX_IDENT, 8'h00);
    $display("test receive done");
    wr(IDX_LCR, lc | 8'h40);
    repeat (2) @(posedge hclk);
    check("break", {serial_out, infrared_tx_out}, 2'b00);
    repeat (40) @(posedge hclk);
    wr(IDX_LCR, lc);
    repeat (200) @(posedge hclk);
    u_serial_peer.q.delete();
    wr(IDX_MCR, 8'h13);
    repeat (2) @(posedge hclk);
    check("loop_pins", {serial_out, rts_n, dtr_n}, 3'b111);
    rd("mdm_st", IDX_MSR, 8'h33);
    rd("mdm_st", IDX_MSR, 8'h30);
    wr(IDX_DATA, b);
    repeat (200) @(posedge hclk);
    rd("loop_data", IDX_DATA, b);
    wr(IDX_MCR, 8'h03);
    repeat (2) @(posedge hclk);
    check("mdm_pins", {serial_out, rts_n, dtr_n}, 3'b100);
    rd("mdm_st", IDX_MSR, 8'h03);
    {dcd_n, ri_n, dsr_n, cts_n} <= 4'h0;
    rd("mdm_st", IDX_MSR, 8'hfb);
    {dcd_n, ri_n, dsr_n, cts_n} <= 4'hf;
    rd("mdm_st", IDX_MSR, 8'h0f);
    $display("test line done");
    conclude();
  end
endmodule

// ---- serial_port_monitor.sv ----
// Bus and line timing checks for the serial port core.
// Bound to the core and sees only its ports.
`timescale 1ns/1ps
module serial_port_monitor (
  input wire logic        hclk,      // Clock.
  input wire logic        hresetn,   // Reset, low.
  input wire logic        hsel,      // Select.
  input wire logic [1:0]  htrans,    // Type.
  input wire logic        hwrite,    // Write.
  input wire logic        hready,    // Ready in.
  input wire logic [31:0] hrdata,    // Read data.
  input wire logic        hreadyout, // Ready out.
  input wire logic        hresp,     // Response.
  input wire logic        serial_out // Line out.
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_rd; hsel && hready && htrans[1] && !hwrite; endsequence
  sequence s_wr; hsel && hready && htrans[1] && hwrite; endsequence
  sequence s_wait; !hreadyout ##1 hreadyout; endsequence
  property p_rd_wait; s_rd |=> s_wait; endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("read wait state wrong");
  property p_rd_hi; s_rd ##1 s_wait |-> hrdata[31:8] == 24'h0; endproperty
  a_rd_hi: assert property (p_rd_hi)
    else $error("read data upper bits set");
  property p_wr; s_wr |=> hreadyout && $stable(hrdata); endproperty
  a_wr: assert property (p_wr)
    else $error("write not zero wait");
  property p_one_wait; !hreadyout |=> hreadyout; endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("wait longer than one cycle");
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay)
    else $error("response not okay");
  property p_bit; $changed(serial_out) |=> $stable(serial_out)[*8]; endproperty
  a_bit: assert property (p_bit)
    else $error("line bit too short");
  property p_start; $fell(serial_out) |-> (!serial_out)[*8]; endproperty
  a_start: assert property (p_start)
    else $error("start bit too short");
  property p_stop; $rose(serial_out) |-> serial_out[*8]; endproperty
  a_stop: assert property (p_stop)
    else $error("high bit too short");
endmodule
bind serial_port_core serial_port_monitor u_serial_port_monitor (.hclk,
  .hresetn, .hsel, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
  .serial_out);

// ---- serial_port_pkg.sv ----
// Constants, field layout and record types of the serial port core.
// Assumes a 40 MHz register clock that also clocks the baud generator.
package serial_port_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [2:0] IDX_DATA  = 3'h0;
  localparam logic [2:0] IDX_IER   = 3'h1;
  localparam logic [2:0] IDX_IDENT = 3'h2;
  localparam logic [2:0] IDX_LCR   = 3'h3;
  localparam logic [2:0] IDX_MCR   = 3'h4;
  localparam logic [2:0] IDX_LSR   = 3'h5;
  localparam logic [2:0] IDX_MSR   = 3'h6;
  localparam logic [2:0] IDX_SCR   = 3'h7;

  // Queue control field positions.
  localparam int QC_ENABLE   = 0;
  localparam int QC_RX_RESET = 1;
  localparam int QC_TX_RESET = 2;
  localparam int QC_DMA      = 3;
  localparam int QC_LVL_LO   = 6;

  // Modem control field positions.
  localparam int MC_DTR  = 0;
  localparam int MC_RTS  = 1;
  localparam int MC_RI   = 2;
  localparam int MC_IRQ  = 3;
  localparam int MC_LOOP = 4;

  // Reset values.
  localparam logic [7:0]  LCR_RST = 8'h03;
  localparam logic [7:0]  MCR_RST = 8'h00;
  localparam logic [7:0]  IER_RST = 8'h00;
  localparam logic [7:0]  SCR_RST = 8'h00;
  // 40 MHz / 16 / 80 gives the 31250 bit/s instrument link rate.
  localparam logic [15:0] DIV_RST = 16'h0050;

  // Timing counts in sixteen-times ticks.
  localparam logic [5:0] TICKS_BIT    = 6'h10;
  localparam logic [5:0] TICKS_HALF   = 6'h08;
  localparam logic [5:0] TICKS_STOP15 = 6'h18;
  localparam logic [5:0] TICKS_STOP2  = 6'h20;

  // Interrupt identification codes, bits 3..1.
  localparam logic [2:0] ID_LINE = 3'h3;
  localparam logic [2:0] ID_RX   = 3'h2;
  localparam logic [2:0] ID_TX   = 3'h1;
  localparam logic [2:0] ID_MDM  = 3'h0;

  typedef struct packed {
    logic       dlab;
    logic       brk;
    logic       stick;
    logic       even;
    logic       par_en;
    logic       stop_x;
    logic [1:0] wl;
  } line_ctrl_s;

  typedef struct packed {
    logic       brk;
    logic       ferr;
    logic       perr;
    logic [7:0] data;
  } rx_entry_s;

  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } modem_in_s;

endpackage
